// ==== hw/bsp_consts.svh ====
// Strap and pin-mux constants for the boot strap pin configuration block.
// Assumes inclusion by the package, the design modules, the checker and the testbench.
`ifndef BSP_CONSTS_SVH
`define BSP_CONSTS_SVH
`define BSP_ROM_BOOT_ADDR 32'h0000_8000
`define BSP_FLASH_BOOT_ADDR 32'h0200_0000
`define BSP_BOOT_ASYNC 3'h1
`define BSP_BOOT_DEFAULT 3'h0
`define BSP_CFG_DEFAULT 3'h0
`define BSP_CFG_WIDE_BIT 2
`define BSP_SETUP_CYCLES 5'h10
`define BSP_STROBE_CYCLES 7'h40
`define BSP_HOLD_CYCLES 4'h8
`define BSP_NUM_LOW_PINS 16
`define BSP_NUM_UPPER_PINS 7
`define BSP_NUM_DATA_HI 8
`define BSP_SYNC_STAGES 3
`endif

// ==== hw/bsp_pkg.sv ====
// Types shared by the boot strap pin configuration block.
// Assumes bsp_consts.svh is on the include path.
`include "bsp_consts.svh"
package bsp_pkg;
    typedef enum logic [2:0] {
        BSP_SRC_NAND, BSP_SRC_ASYNC, BSP_SRC_CARD, BSP_SRC_SERIAL,
        BSP_SRC_USB, BSP_SRC_SPI, BSP_SRC_ETH, BSP_SRC_HOST
    } bsp_src_t;
    typedef struct packed {
        logic [4:0] setup;
        logic [6:0] strobe;
        logic [3:0] hold;
    } bsp_wait_t;
    typedef struct packed {
        logic [15:0] low_addr_en;
        logic [1:0] bank_en;
        logic first_is_a14;
        logic first_is_bank0;
        logic data_hi_en;
        logic [6:0] upper_addr_en;
        logic wide;
    } bsp_pins_t;
endpackage : bsp_pkg

// ==== hw/bsp_strap_sync.sv ====
// Three-stage synchroniser with agreement filter for strap pins.
// Assumes pins are asynchronous to ref_clk.
`timescale 1ns/100ps
`include "bsp_consts.svh"
module bsp_strap_sync #(
    parameter int WIDTH = 6
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] out_reg;

    // Shift chain; first stage feeds second only
    always_ff @(posedge ref_clk) begin
        s1_reg <= pin_in;
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
    end

    // Accept a value while reset_n is low and stages two and three agree
    always_ff @(posedge ref_clk) begin
        if (!reset_n && s2_reg == s3_reg) begin
            out_reg <= s2_reg;
        end
    end

    assign pin_out = out_reg;
endmodule : bsp_strap_sync

// ==== hw/bsp_boot_strap.sv ====
// Boot strap pin configuration: latches straps during reset and derives
// boot address, pin assignments and default wait states.
// Assumes strap pins are asynchronous and settled while reset_n is low.
// Straps must stay steady for at least five edges of reset.
// Software pin-mux inputs count only once boot_done is high.
// Pin outputs switch one edge after reset_n rises.
// Layout code x11 behaves as x01.
//
// Contract
// - ROM fetch address unless code 001
// - Config strap sets pins after reset
// - Unassigned, non-address pins act as GPIO
// - Address pins contiguous from bank pin one
// - 23 address lines, 2 selects, 8/16 bit
// - Wide mode: bank1 LSB, bank0 bit 14
// - Narrow mode: bank pins two LSBs
// - Upper address pins GPIO until mux four
// - Strap only gates pins, not controller
// - Boot address pin count zero to sixteen
// - Codes pick low address pin layout
// - Codes 1xx enable upper data byte
// - Wait states reset to slowest setting
// - Boot code selects boot source
// - Config bit two selects data width
`timescale 1ns/100ps
`include "bsp_consts.svh"
module bsp_boot_strap #(
    parameter int NUM_LOW = `BSP_NUM_LOW_PINS,
    parameter int NUM_UPPER = `BSP_NUM_UPPER_PINS
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [2:0] boot_source_select,
    input wire logic [2:0] async_mem_pin_config,
    input wire logic boot_done,
    input wire logic sw_mux_valid,
    input wire logic [1:0] pin_mux_register_two,
    input wire logic [NUM_UPPER-1:0] pin_mux_register_four,
    output logic [31:0] boot_fetch_addr,
    output bsp_pkg::bsp_src_t boot_source,
    output bsp_pkg::bsp_pins_t pin_assign,
    output logic [NUM_LOW-1:0] low_pin_gpio,
    output logic [4:0] addr_pin_count,
    output bsp_pkg::bsp_wait_t wait_default,
    output logic config_locked
);
    logic [5:0] strap_sync;
    logic [2:0] boot_sel_reg;
    logic [2:0] mem_cfg_reg;
    logic locked_reg;
    logic sw_mode_reg;
    bsp_pkg::bsp_pins_t pins_next;
    bsp_pkg::bsp_pins_t pins_reg;
    logic [4:0] count_next;
    logic [4:0] count_reg;
    logic [31:0] addr_reg;
    bsp_pkg::bsp_src_t src_reg;
    bsp_pkg::bsp_wait_t wait_reg;
    logic [NUM_LOW-1:0] gpio_reg; // Registered GPIO fallback per low pin

    // Layout codes x00 keep only the two fixed address pins
    function automatic logic layout_is_short(input logic [1:0] layout);
        layout_is_short = (layout == 2'h0);
    endfunction : layout_is_short

    // Decode the strap layout of the low address pins
    // Only the short layout differs; all others enable every pin
    function automatic logic [15:0] low_enables(input logic [1:0] layout);
        case (layout)
            2'h0: low_enables = 16'h0018;
            default: low_enables = 16'hffff;
        endcase
    endfunction : low_enables

    // Strap pins through the filtered synchroniser
    // Straps are bare board levels, so they cross into ref_clk first
    // Three stages then an agreement filter reject a bouncing strap
    bsp_strap_sync #(
        .WIDTH(6)
    ) u_sync (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .pin_in({boot_source_select, async_mem_pin_config}),
        .pin_out(strap_sync)
    );

    // Capture during reset, hold after
    // After release these pins carry address traffic, so the
    // latch must close on the first edge that sees reset_n high
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            boot_sel_reg <= strap_sync[5:3];
            mem_cfg_reg <= strap_sync[2:0];
        end
    end

    // Lock flag marks reset release
    // Consumers may trust every output once this is high
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            locked_reg <= 1'b0;
        end else begin
            locked_reg <= 1'b1;
        end
    end

    // Software mux only after boot
    // Sticky: dropping boot_done later cannot hand pins back
    // to the straps; only a reset does
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            sw_mode_reg <= 1'b0;
        end else if (boot_done && sw_mux_valid) begin
            sw_mode_reg <= 1'b1;
        end
    end

    // Combinational pin assignment from straps and software mux
    // Everything but low_addr_en defaults to GPIO; an unknown layout code takes
    // the low_enables default and drives an address onto all 16 low pins
    always_comb begin
        pins_next = '0;
        // Data bus is 8 or 16 bits only
        pins_next.wide = mem_cfg_reg[`BSP_CFG_WIDE_BIT];
        pins_next.low_addr_en = low_enables(mem_cfg_reg[1:0]);
        // Codes x11 reuse the x01 layout
        pins_next.first_is_a14 = mem_cfg_reg[0];
        pins_next.first_is_bank0 = (mem_cfg_reg[1:0] == 2'h2);
        // Wide: bank1 half-word bit
        // Bank pin one is the lowest address bit of every long layout
        pins_next.bank_en[1] = !layout_is_short(mem_cfg_reg[1:0]);
        pins_next.bank_en[0] = pins_next.first_is_bank0;
        // Narrow: both bank pins low bits
        // The byte address needs both bank pins in narrow mode
        if (!pins_next.wide && !layout_is_short(mem_cfg_reg[1:0])) begin
            pins_next.bank_en = 2'h3;
        end
        pins_next.data_hi_en = mem_cfg_reg[2];
        // Upper address only by mux four
        // 16 low plus 7 upper address pins in all
        // Upper pins stay GPIO at boot while the board pulls them down
        if (sw_mode_reg) begin
            pins_next.upper_addr_en = pin_mux_register_four;
            pins_next.first_is_a14 = pins_next.first_is_a14 | pin_mux_register_two[1];
            pins_next.first_is_bank0 = pins_next.first_is_bank0 | pin_mux_register_two[0];
        end
    end

    // Address pin count, zero to sixteen
    // Short layouts report zero: their two fixed pins are not
    // a boot-time address range from bank pin one
    always_comb begin
        count_next = '0;
        for (int i = 0; i < NUM_LOW; i++) begin
            count_next = count_next + 5'(pins_next.low_addr_en[i]);
        end
        if (layout_is_short(mem_cfg_reg[1:0])) begin
            count_next = 5'h0;
        end
    end

    // Register pin assignment
    // Registered so the pins switch once, cleanly, after release
    // Reset value zero puts every low pin in GPIO
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            pins_reg <= '0;
            count_reg <= 5'h0;
        end else begin
            pins_reg <= pins_next;
            count_reg <= count_next;
        end
    end

    // Boot fetch address and source
    // Decided from the latched code, never from the live pins
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            addr_reg <= `BSP_ROM_BOOT_ADDR;
            src_reg <= bsp_pkg::BSP_SRC_NAND;
        end else begin
            addr_reg <= (boot_sel_reg == `BSP_BOOT_ASYNC) ? `BSP_FLASH_BOOT_ADDR
                                                          : `BSP_ROM_BOOT_ADDR;
            src_reg <= bsp_pkg::bsp_src_t'(boot_sel_reg);
        end
    end

    // Controller timing untouched by straps
    // Reset-only load: software tunes timing in the controller
    // itself, this block only supplies the power-up value
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            wait_reg <= '{`BSP_SETUP_CYCLES, `BSP_STROBE_CYCLES, `BSP_HOLD_CYCLES};
        end
    end

    // Non-address low pins fall to GPIO
    // One flop per pin, so the direction never glitches on decode
    for (genvar i = 0; i < NUM_LOW; i++) begin : g_gpio
        always_ff @(posedge ref_clk) begin
            if (!reset_n) begin
                gpio_reg[i] <= 1'b1;
            end else begin
                gpio_reg[i] <= ~pins_next.low_addr_en[i];
            end
        end
    end

    // Outputs straight from their registers
    assign low_pin_gpio = gpio_reg;
    assign pin_assign = pins_reg;
    assign addr_pin_count = count_reg;
    assign boot_fetch_addr = addr_reg;
    assign boot_source = src_reg;
    assign wait_default = wait_reg;
    assign config_locked = locked_reg;
endmodule : bsp_boot_strap

// ==== bench/bsp_strap_board.sv ====
// Board model: strap resistors and the shared address lines.
// Assumes the bench picks the strap codes before each reset.
`timescale 1ns/100ps
module bsp_strap_board (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [2:0] boot_code,
    input wire logic [2:0] cfg_code,
    output logic [2:0] boot_source_select,
    output logic [2:0] async_mem_pin_config
);
    logic [2:0] spin_reg;
    // Address traffic after release, changing every cycle
    always_ff @(posedge ref_clk) begin
        spin_reg <= reset_n ? spin_reg + 3'h3 : 3'h5;
    end
    assign boot_source_select = reset_n ? ~boot_code ^ spin_reg : boot_code;
    assign async_mem_pin_config = reset_n ? ~cfg_code ^ spin_reg : cfg_code;
endmodule : bsp_strap_board

// ==== bench/bsp_boot_strap_properties.sv ====
// Checker for the boot strap block.
// Assumes it is bound to every instance and sees only its ports.
`timescale 1ns/100ps
`include "bsp_consts.svh"
module bsp_boot_strap_chk #(
    parameter int NUM_LOW = 16,
    parameter int NUM_UPPER = 7
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic boot_done,
    input wire logic [31:0] boot_fetch_addr,
    input wire bsp_pkg::bsp_src_t boot_source,
    input wire bsp_pkg::bsp_pins_t pin_assign,
    input wire logic [NUM_LOW-1:0] low_pin_gpio,
    input wire logic [4:0] addr_pin_count,
    input wire bsp_pkg::bsp_wait_t wait_default,
    input wire logic config_locked
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    a_locked_release: assert property ($rose(reset_n) |=> config_locked)
        else $error("not locked after release");
    a_straps_held: assert property (config_locked && $past(config_locked)
        |-> $stable(boot_source) && $stable(boot_fetch_addr)) else $error("straps moved");
    a_rom_or_flash: assert property (config_locked |-> boot_fetch_addr ==
        (boot_source == bsp_pkg::BSP_SRC_ASYNC ? `BSP_FLASH_BOOT_ADDR : `BSP_ROM_BOOT_ADDR))
        else $error("bad fetch address");
    a_gpio_inverse: assert property (low_pin_gpio == ~pin_assign.low_addr_en)
        else $error("gpio not inverse");
    a_wait_slowest: assert property (wait_default == {`BSP_SETUP_CYCLES,
        `BSP_STROBE_CYCLES, `BSP_HOLD_CYCLES}) else $error("bad wait states");
    a_hi_byte_wide: assert property (config_locked |->
        pin_assign.data_hi_en == pin_assign.wide) else $error("data byte vs width");
    a_count_layout: assert property (config_locked && !boot_done |-> addr_pin_count ==
        (pin_assign.bank_en[1] ? 5'h10 : 5'h0))
        else $error("bad pin count");
    a_upper_at_boot: assert property ($rose(config_locked) |->
        pin_assign.upper_addr_en == '0) else $error("upper pins not gpio");
    c_flash: cover property ($rose(config_locked) && boot_source == bsp_pkg::BSP_SRC_ASYNC);
    c_wide: cover property (config_locked && pin_assign.wide);
    c_soft: cover property ($rose(pin_assign.upper_addr_en[0]));
endmodule : bsp_boot_strap_chk
bind bsp_boot_strap bsp_boot_strap_chk #(.NUM_LOW(NUM_LOW), .NUM_UPPER(NUM_UPPER)) chk (
    .ref_clk(ref_clk), .reset_n(reset_n), .boot_done(boot_done),
    .boot_fetch_addr(boot_fetch_addr), .boot_source(boot_source), .pin_assign(pin_assign),
    .low_pin_gpio(low_pin_gpio), .addr_pin_count(addr_pin_count),
    .wait_default(wait_default), .config_locked(config_locked));

// ==== bench/test_bsp_boot_strap.sv ====
// Testbench: boots with every strap code, then the software mux.
// Assumes the board model drives the strap pins.
`timescale 1ns/100ps
`include "bsp_consts.svh"
module test_bsp_boot_strap;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic boot_done = 1'b0;
    logic sw_mux_valid = 1'b0;
    logic [1:0] mux_two = 2'h0;
    logic [6:0] mux_four = 7'h0;
    logic [2:0] boot_code = 3'h0;
    logic [2:0] cfg_code = 3'h0;
    logic [2:0] boot_pins;
    logic [2:0] cfg_pins;
    logic [31:0] fetch;
    bsp_pkg::bsp_src_t src;
    bsp_pkg::bsp_pins_t pins;
    logic [4:0] count;
    logic locked;
    logic [15:0] gpio;
    bsp_pkg::bsp_wait_t waits;
    int err_total = 0;
    int tests_run = 0;
    bsp_strap_board board (.ref_clk(ref_clk), .reset_n(reset_n), .boot_code(boot_code),
        .cfg_code(cfg_code), .boot_source_select(boot_pins), .async_mem_pin_config(cfg_pins));
    bsp_boot_strap uut (.ref_clk(ref_clk), .reset_n(reset_n), .boot_source_select(boot_pins),
        .async_mem_pin_config(cfg_pins), .boot_done(boot_done), .sw_mux_valid(sw_mux_valid),
        .pin_mux_register_two(mux_two), .pin_mux_register_four(mux_four),
        .boot_fetch_addr(fetch), .boot_source(src), .pin_assign(pins), .low_pin_gpio(gpio),
        .addr_pin_count(count), .wait_default(waits), .config_locked(locked));
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic tally_and_finish();
        if (err_total == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    // Straps in reset for 10 cycles, release, one edge
    task automatic boot_with(input logic [2:0] b, input logic [2:0] c);
        reset_n = 1'b0;
        boot_done = 1'b0;
        sw_mux_valid = 1'b0;
        boot_code = b;
        cfg_code = c;
        repeat (10) @(negedge ref_clk);
        reset_n = 1'b1;
        @(negedge ref_clk);
    endtask : boot_with
    task automatic check_boot(input logic [2:0] b, input logic [2:0] c);
        logic [1:0] lay;
        lay = c[1:0];
        cmp("fetch", b == `BSP_BOOT_ASYNC ? `BSP_FLASH_BOOT_ADDR : `BSP_ROM_BOOT_ADDR, fetch);
        cmp("source", {29'h0, b}, {29'h0, src});
        cmp("width", {31'h0, c[2]}, {31'h0, pins.wide});
        cmp("data_hi", {31'h0, c[2]}, {31'h0, pins.data_hi_en});
        cmp("first", {30'h0, lay == 2'h2, lay[0]},
            {30'h0, pins.first_is_bank0, pins.first_is_a14});
        cmp("low_pins", lay == 2'h0 ? 32'h18 : 32'hffff, {16'h0, pins.low_addr_en});
        cmp("gpio", lay == 2'h0 ? 32'hffe7 : 32'h0, {16'h0, gpio});
        cmp("wait", {16'h0, `BSP_SETUP_CYCLES, `BSP_STROBE_CYCLES, `BSP_HOLD_CYCLES},
            {16'h0, waits});
        cmp("count", lay == 2'h0 ? 32'h0 : 32'h10, {27'h0, count});
        cmp("upper", 32'h0, {25'h0, pins.upper_addr_en});
        cmp("locked", 32'h1, {31'h0, locked});
    endtask : check_boot
    // Every boot code against every layout code
    task automatic scen_all_codes();
        for (int b = 0; b < 8; b++) begin
            for (int c = 0; c < 8; c++) begin
                boot_with(b[2:0], c[2:0]);
                check_boot(b[2:0], c[2:0]);
            end
        end
    endtask : scen_all_codes
    // Pins toggle and mux is offered before boot ends
    task automatic scen_held();
        boot_with(3'h1, 3'h5);
        mux_four = 7'h7f;
        mux_two = 2'h2;
        sw_mux_valid = 1'b1;
        repeat (6) @(negedge ref_clk);
        check_boot(3'h1, 3'h5);
    endtask : scen_held
    // Software mux takes over once boot is done
    task automatic scen_sw_mux();
        int n;
        boot_with(3'h0, 3'h0);
        mux_four = 7'h7f;
        mux_two = 2'h3;
        sw_mux_valid = 1'b1;
        boot_done = 1'b1;
        n = 0;
        while (pins.upper_addr_en !== 7'h7f && n < 8) begin
            @(negedge ref_clk);
            n++;
        end
        cmp("mux_upper", 32'h7f, {25'h0, pins.upper_addr_en});
        if (pins.upper_addr_en !== 7'h7f) begin
            tally_and_finish();
        end else begin
            cmp("mux_first", 32'h3, {30'h0, pins.first_is_bank0, pins.first_is_a14});
            boot_with(3'h2, 3'h2);
            check_boot(3'h2, 3'h2);
        end
    endtask : scen_sw_mux
    initial begin
        scen_all_codes();
        scen_held();
        scen_sw_mux();
        tally_and_finish();
    end
endmodule : test_bsp_boot_strap
